/* core/bsd_compare.sv */
// Purpose: Compares channel results against thresholds and gathers fault bits
// Assumes: Results arrive in any channel order, done follows the last one
// Notes: Fault bits are staged and released only at done
`timescale 1ns/1ps
`default_nettype none
module bsd_compare (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Mode and thresholds
  input wire logic [2:0] mode,
  input wire logic [11:0] measured,
  input wire logic [15:0] short_threshold,
  input wire logic [15:0] low_threshold,
  input wire logic [15:0] high_threshold,
  // Results
  bsd_result_if.dst res,
  // Fault bits for one acquisition, pulse
  output logic [11:0] fault_bits,
  output logic fault_valid
);
  logic [11:0] staged;
  logic [11:0] next_staged;
  logic [11:0] next_fault_bits;
  logic next_fault_valid;
  logic hit;

  always_comb begin
    hit = 1'b0;
    case (mode)
      bsd_pkg::MODE_SHORT: hit = res.data < short_threshold; // [RULE8]
      bsd_pkg::MODE_OPEN, bsd_pkg::MODE_ODD_WIRE, bsd_pkg::MODE_EVEN_WIRE:
        hit = (res.data > high_threshold) || (res.data < low_threshold); // [RULE10] [RULE13]
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_staged = staged;
    next_fault_bits = fault_bits;
    next_fault_valid = 1'b0;
    if (res.valid && res.chan < 4'd12 && measured[res.chan] && hit) begin
      next_staged[res.chan] = 1'b1; // [RULE18]
    end
    if (res.done) begin
      // Released only once the whole acquisition is in
      next_fault_bits = next_staged; // [RULE18]
      next_fault_valid = mode != bsd_pkg::MODE_OFF;
      next_staged = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      staged <= '0;
      fault_bits <= '0;
      fault_valid <= 1'b0;
    end else begin
      staged <= next_staged;
      fault_bits <= next_fault_bits;
      fault_valid <= next_fault_valid;
    end
  end
endmodule
`default_nettype wire

/* core/bsd_pkg.sv */
// Purpose: Shared constants and types for the balance switch diagnostics block
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Offsets are word indices on a 16-bit data path
package bsd_pkg;
  localparam logic [3:0] ADDR_MEASURE = 4'h0;
  localparam logic [3:0] ADDR_BALANCE = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_SHORT_THR = 4'h3;
  localparam logic [3:0] ADDR_LOW_THR = 4'h4;
  localparam logic [3:0] ADDR_HIGH_THR = 4'h5;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_SOURCES = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EFFECTIVE = 4'h9;
  // Config register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DSEL_LSB = 3;
  localparam int CFG_ALT_BIT = 6;
  localparam int CFG_POL_BIT = 7;
  // Source register fields
  localparam int SRC_MAG_LSB = 0;
  localparam int SRC_DIR_BIT = 4;
  localparam int SRC_AUX_LSB = 5;
  localparam int SRC_MUXEN_BIT = 7;
  localparam int SRC_SPLIT_BIT = 8;
  localparam int SRC_BUS_BIT = 9;
  // Mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SHORT = 3'h1;
  localparam logic [2:0] MODE_OPEN = 3'h2;
  localparam logic [2:0] MODE_ODD_WIRE = 3'h5;
  localparam logic [2:0] MODE_EVEN_WIRE = 3'h6;
  localparam logic [2:0] DSEL_FULL_SCALE = 3'h5;
  localparam logic [15:0] FULL_SCALE_RESULT = 16'hfff0;
  localparam logic [11:0] ODD_SWITCHES = 12'h555;
  localparam logic [11:0] EVEN_SWITCHES = 12'haaa;
  localparam logic [11:0] NO_SWITCHES = 12'h000;
  localparam logic [2:0] NO_EXTRA_MEAS = 3'h0;
  // Reset values
  localparam logic [14:0] MEASURE_RESET = 15'h0000;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [15:0] HIGH_THR_RESET = 16'hffff;
endpackage

/* core/bsd_result_if.sv */
// Purpose: Carries one channel result from the acquisition engine
// Assumes: Single clock domain
// Notes: Valid is a one-cycle pulse per channel
`timescale 1ns/1ps
`default_nettype none
interface bsd_result_if;
  logic valid;
  logic [3:0] chan;
  logic [15:0] data;
  logic done;
  modport src(output valid, output chan, output data, output done);
  modport dst(input valid, input chan, input data, input done);
endinterface
`default_nettype wire

/* core/bsd_top.sv */
// Purpose: Switch and sense-wire diagnostic mode controller with test source controls
// Assumes: Host loads thresholds and starts the acquisition itself
// Notes: Stored settings are never altered by a mode, so leaving it restores them
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] Source select five forces bipolar, full-scale input gives fff0 result
// [RULE2] Mode 1 short, 2 open, 5 odd wire, 6 even wire
// [RULE3] Any mode preconfigures acquisition, compares automatically, sets flags
// [RULE4] Host loads thresholds and starts the acquisition
// [RULE5] Over, under and mismatch alerts suppressed during any mode
// [RULE6] Clearing mode restores every overridden setting
// [RULE7] Short mode: extra measures off, switches off, alternate path on
// [RULE8] Short mode: result below short threshold sets switch flag
// [RULE9] Open mode: bipolar, alternate path, measures copy switch enables
// [RULE10] Open mode: result outside low/high window sets flag
// [RULE11] Odd wire forces 555, even wire aaa, plus open mode settings
// [RULE12] Host waits settling time before starting wire acquisition
// [RULE13] Wire modes: result outside window sets flag
// [RULE14] Thirteen cell and two aux source enables, one magnitude code
// [RULE15] Direction bit sources or sinks, input zero always sources
// [RULE16] Mux sources drive both buses unless split selects one
// [RULE17] Bus select one drives odd bus, zero drives even bus
// [RULE18] Compare only measured channels, only after results complete
module bsd_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Acquisition result stream
  input wire logic res_valid,
  input wire logic [3:0] res_chan,
  input wire logic [15:0] res_data,
  input wire logic res_done,
  // Alert comparisons from the measurement path
  input wire logic over_hit,
  input wire logic under_hit,
  input wire logic mismatch_hit,
  // Effective acquisition configuration
  output logic [14:0] measure_enables,
  output logic [11:0] balance_switch_enables,
  output logic alternate_path,
  output logic bipolar,
  output logic [15:0] full_scale_result,
  output logic full_scale_force,
  // Gated alerts
  output logic cell_over_alert,
  output logic cell_under_alert,
  output logic path_mismatch_alert,
  // Input-side test sources
  output logic [12:0] cell_source_on,
  output logic [12:0] cell_source_sink,
  output logic [1:0] aux_source_on,
  output logic [1:0] aux_source_sink,
  output logic [3:0] source_magnitude_code,
  // Mux output-side test sources
  output logic mux_even_on,
  output logic mux_odd_on
);
  // Stored host settings
  logic [14:0] measure_set;
  logic [11:0] balance_set;
  logic [7:0] result_a_config;
  logic [15:0] short_threshold;
  logic [15:0] low_threshold;
  logic [15:0] high_threshold;
  logic [11:0] switch_fault_flags;
  logic [12:0] cell_source_enables;
  logic [9:0] source_ctrl;
  logic [14:0] next_measure_set;
  logic [11:0] next_balance_set;
  logic [7:0] next_result_a_config;
  logic [15:0] next_short_threshold;
  logic [15:0] next_low_threshold;
  logic [15:0] next_high_threshold;
  logic [11:0] next_switch_fault_flags;
  logic [12:0] next_cell_source_enables;
  logic [9:0] next_source_ctrl;
  logic [15:0] next_reg_rdata;
  // Effective values
  logic [14:0] next_measure_enables;
  logic [11:0] next_balance_switch_enables;
  logic next_alternate_path;
  logic next_bipolar;
  logic next_full_scale_force;
  logic next_over;
  logic next_under;
  logic next_mismatch;
  logic [12:0] next_cell_on;
  logic [12:0] next_cell_sink;
  logic [1:0] next_aux_on;
  logic [1:0] next_aux_sink;
  logic next_mux_even;
  logic next_mux_odd;
  logic [2:0] switch_result_a_mode;
  logic [2:0] result_a_source_select;
  logic mode_active;
  logic [11:0] fault_bits;
  logic fault_valid;

  typedef enum logic [1:0] {BSD_IDLE, BSD_ARMED, BSD_DONE} bsd_state_t;
  bsd_state_t state;
  bsd_state_t next_state;

  bsd_result_if res_bus ();

  assign res_bus.valid = res_valid;
  assign res_bus.chan = res_chan;
  assign res_bus.data = res_data;
  assign res_bus.done = res_done;

  function automatic logic is_mode(input logic [2:0] m);
    is_mode = (m == bsd_pkg::MODE_SHORT) || (m == bsd_pkg::MODE_OPEN) ||
              (m == bsd_pkg::MODE_ODD_WIRE) || (m == bsd_pkg::MODE_EVEN_WIRE); // [RULE2]
  endfunction

  assign switch_result_a_mode = result_a_config[bsd_pkg::CFG_MODE_LSB +: 3];
  assign result_a_source_select = result_a_config[bsd_pkg::CFG_DSEL_LSB +: 3];
  assign mode_active = is_mode(switch_result_a_mode);

  bsd_compare u_compare (
    .mclk(mclk),
    .rst_n(rst_n),
    .mode(mode_active ? switch_result_a_mode : bsd_pkg::MODE_OFF),
    .measured(measure_enables[11:0]),
    .short_threshold(short_threshold),
    .low_threshold(low_threshold),
    .high_threshold(high_threshold),
    .res(res_bus),
    .fault_bits(fault_bits),
    .fault_valid(fault_valid)
  );

  // Overrides computed from stored settings only, so clearing restores them
  always_comb begin
    next_measure_enables = measure_set; // [RULE6]
    next_balance_switch_enables = balance_set;
    next_alternate_path = result_a_config[bsd_pkg::CFG_ALT_BIT];
    next_bipolar = result_a_config[bsd_pkg::CFG_POL_BIT];
    case (switch_result_a_mode)
      bsd_pkg::MODE_SHORT: begin
        next_measure_enables[14:12] = bsd_pkg::NO_EXTRA_MEAS; // [RULE7]
        next_balance_switch_enables = bsd_pkg::NO_SWITCHES; // [RULE7]
        next_alternate_path = 1'b1; // [RULE7]
      end
      bsd_pkg::MODE_OPEN: begin
        next_measure_enables = {bsd_pkg::NO_EXTRA_MEAS, balance_set}; // [RULE9]
        next_alternate_path = 1'b1; // [RULE9]
        next_bipolar = 1'b1; // [RULE9]
      end
      bsd_pkg::MODE_ODD_WIRE: begin
        next_balance_switch_enables = bsd_pkg::ODD_SWITCHES; // [RULE11]
        next_measure_enables = {bsd_pkg::NO_EXTRA_MEAS, bsd_pkg::ODD_SWITCHES}; // [RULE11]
        next_alternate_path = 1'b1; // [RULE11]
        next_bipolar = 1'b1; // [RULE11]
      end
      bsd_pkg::MODE_EVEN_WIRE: begin
        next_balance_switch_enables = bsd_pkg::EVEN_SWITCHES; // [RULE11]
        next_measure_enables = {bsd_pkg::NO_EXTRA_MEAS, bsd_pkg::EVEN_SWITCHES}; // [RULE11]
        next_alternate_path = 1'b1; // [RULE11]
        next_bipolar = 1'b1; // [RULE11]
      end
      default: begin
      end
    endcase
    next_full_scale_force = result_a_source_select == bsd_pkg::DSEL_FULL_SCALE; // [RULE1]
    if (next_full_scale_force) begin
      next_bipolar = 1'b1; // [RULE1]
    end
    next_over = over_hit && !mode_active; // [RULE5]
    next_under = under_hit && !mode_active; // [RULE5]
    next_mismatch = mismatch_hit && !mode_active; // [RULE5]
  end

  // Test source steering
  always_comb begin
    next_cell_on = cell_source_enables; // [RULE14]
    next_aux_on = source_ctrl[bsd_pkg::SRC_AUX_LSB +: 2]; // [RULE14]
    next_cell_sink = cell_source_enables &
                     {13{source_ctrl[bsd_pkg::SRC_DIR_BIT]}}; // [RULE15]
    next_cell_sink[0] = 1'b0; // [RULE15]
    next_aux_sink = next_aux_on & {2{source_ctrl[bsd_pkg::SRC_DIR_BIT]}}; // [RULE15]
    next_mux_even = source_ctrl[bsd_pkg::SRC_MUXEN_BIT] &&
                    (!source_ctrl[bsd_pkg::SRC_SPLIT_BIT] ||
                     !source_ctrl[bsd_pkg::SRC_BUS_BIT]); // [RULE16] [RULE17]
    next_mux_odd = source_ctrl[bsd_pkg::SRC_MUXEN_BIT] &&
                   (!source_ctrl[bsd_pkg::SRC_SPLIT_BIT] ||
                    source_ctrl[bsd_pkg::SRC_BUS_BIT]); // [RULE16] [RULE17]
  end

  // Sequence: a mode arms, an acquisition completes it
  always_comb begin
    next_state = state;
    case (state)
      BSD_IDLE: if (mode_active) next_state = BSD_ARMED; // [RULE3]
      BSD_ARMED: begin
        if (!mode_active) next_state = BSD_IDLE;
        else if (fault_valid) next_state = BSD_DONE;
      end
      BSD_DONE: if (!mode_active) next_state = BSD_IDLE;
      default: next_state = BSD_IDLE;
    endcase
  end

  // Register writes; hardware set wins over a host clear
  always_comb begin
    next_measure_set = measure_set;
    next_balance_set = balance_set;
    next_result_a_config = result_a_config;
    next_short_threshold = short_threshold;
    next_low_threshold = low_threshold;
    next_high_threshold = high_threshold;
    next_switch_fault_flags = switch_fault_flags;
    next_cell_source_enables = cell_source_enables;
    next_source_ctrl = source_ctrl;
    if (reg_wr) begin
      case (reg_addr)
        bsd_pkg::ADDR_MEASURE: next_measure_set = reg_wdata[14:0];
        bsd_pkg::ADDR_BALANCE: next_balance_set = reg_wdata[11:0];
        bsd_pkg::ADDR_CONFIG: next_result_a_config = reg_wdata[7:0];
        bsd_pkg::ADDR_SHORT_THR: next_short_threshold = reg_wdata;
        bsd_pkg::ADDR_LOW_THR: next_low_threshold = reg_wdata;
        bsd_pkg::ADDR_HIGH_THR: next_high_threshold = reg_wdata;
        bsd_pkg::ADDR_FLAGS: next_switch_fault_flags = switch_fault_flags & ~reg_wdata[11:0];
        bsd_pkg::ADDR_SOURCES: next_cell_source_enables = reg_wdata[12:0];
        bsd_pkg::ADDR_STATUS: next_source_ctrl = reg_wdata[9:0];
        default: begin
        end
      endcase
    end
    if (fault_valid && mode_active) begin
      next_switch_fault_flags = next_switch_fault_flags | fault_bits; // [RULE3]
    end
    next_reg_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        bsd_pkg::ADDR_MEASURE: next_reg_rdata = {1'b0, measure_set};
        bsd_pkg::ADDR_BALANCE: next_reg_rdata = {4'h0, balance_set};
        bsd_pkg::ADDR_CONFIG: next_reg_rdata = {8'h00, result_a_config};
        bsd_pkg::ADDR_SHORT_THR: next_reg_rdata = short_threshold;
        bsd_pkg::ADDR_LOW_THR: next_reg_rdata = low_threshold;
        bsd_pkg::ADDR_HIGH_THR: next_reg_rdata = high_threshold;
        bsd_pkg::ADDR_FLAGS: next_reg_rdata = {4'h0, switch_fault_flags};
        bsd_pkg::ADDR_SOURCES: next_reg_rdata = {3'h0, cell_source_enables};
        bsd_pkg::ADDR_STATUS: next_reg_rdata = {4'h0, state == BSD_DONE, state == BSD_ARMED,
                                                source_ctrl};
        bsd_pkg::ADDR_EFFECTIVE: next_reg_rdata = {alternate_path, measure_enables};
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      measure_set <= bsd_pkg::MEASURE_RESET;
      balance_set <= bsd_pkg::NO_SWITCHES;
      result_a_config <= 8'h00;
      short_threshold <= bsd_pkg::THR_RESET;
      low_threshold <= bsd_pkg::THR_RESET;
      high_threshold <= bsd_pkg::HIGH_THR_RESET;
      switch_fault_flags <= 12'h000;
      cell_source_enables <= 13'h0000;
      source_ctrl <= 10'h000;
      reg_rdata <= 16'h0000;
      state <= BSD_IDLE;
      measure_enables <= bsd_pkg::MEASURE_RESET;
      balance_switch_enables <= bsd_pkg::NO_SWITCHES;
      alternate_path <= 1'b0;
      bipolar <= 1'b0;
      full_scale_force <= 1'b0;
      full_scale_result <= bsd_pkg::FULL_SCALE_RESULT;
      cell_over_alert <= 1'b0;
      cell_under_alert <= 1'b0;
      path_mismatch_alert <= 1'b0;
      cell_source_on <= 13'h0000;
      cell_source_sink <= 13'h0000;
      aux_source_on <= 2'h0;
      aux_source_sink <= 2'h0;
      source_magnitude_code <= 4'h0;
      mux_even_on <= 1'b0;
      mux_odd_on <= 1'b0;
    end else begin
      measure_set <= next_measure_set;
      balance_set <= next_balance_set;
      result_a_config <= next_result_a_config;
      short_threshold <= next_short_threshold;
      low_threshold <= next_low_threshold;
      high_threshold <= next_high_threshold;
      switch_fault_flags <= next_switch_fault_flags;
      cell_source_enables <= next_cell_source_enables;
      source_ctrl <= next_source_ctrl;
      reg_rdata <= next_reg_rdata;
      state <= next_state;
      measure_enables <= next_measure_enables;
      balance_switch_enables <= next_balance_switch_enables;
      alternate_path <= next_alternate_path;
      bipolar <= next_bipolar;
      full_scale_force <= next_full_scale_force;
      full_scale_result <= bsd_pkg::FULL_SCALE_RESULT; // [RULE1]
      cell_over_alert <= next_over;
      cell_under_alert <= next_under;
      path_mismatch_alert <= next_mismatch;
      cell_source_on <= next_cell_on;
      cell_source_sink <= next_cell_sink;
      aux_source_on <= next_aux_on;
      aux_source_sink <= next_aux_sink;
      source_magnitude_code <= source_ctrl[bsd_pkg::SRC_MAG_LSB +: 4]; // [RULE14]
      mux_even_on <= next_mux_even;
      mux_odd_on <= next_mux_odd;
    end
  end
endmodule
`default_nettype wire

/* sim/bsd_acq_model.sv */
// Purpose: Acquisition engine stand-in feeding channel results
// Assumes: One result per cycle in channel order, done after the last
// Notes: Idle lines toggle so stale values are never mistaken for data
`timescale 1ns/1ps
`default_nettype none
module bsd_acq_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic send_all,
  input wire logic [11:0] chan_en,
  input wire logic [191:0] chan_data,
  // Result stream
  output logic res_valid,
  output logic [3:0] res_chan,
  output logic [15:0] res_data,
  output logic res_done
);
  logic busy;
  logic [3:0] idx;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      idx <= 4'h0;
      res_valid <= 1'b0;
      res_done <= 1'b0;
      res_chan <= 4'h0;
      res_data <= 16'h0000;
    end else begin
      res_valid <= 1'b0;
      res_done <= 1'b0;
      res_chan <= ~res_chan;
      res_data <= ~res_data;
      if (start) begin
        busy <= 1'b1;
        idx <= 4'h0;
      end else if (busy) begin
        if (idx == 4'hc) begin
          busy <= 1'b0;
          res_done <= 1'b1;
        end else begin
          idx <= idx + 4'h1;
          // Send-all mode leaks unmeasured channels on purpose
          if (chan_en[idx] || send_all) begin
            res_valid <= 1'b1;
            res_chan <= idx;
            res_data <= chan_data[idx*16 +: 16];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/bsd_monitor.sv */
// Purpose: Port-level checker for the switch diagnostic controller
// Assumes: Effective outputs trail the stored settings by one edge
// Notes: Mode and source settings shadowed from writes
`timescale 1ns/1ps
`default_nettype none
module bsd_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Raw and gated alerts
  input wire logic over_hit,
  input wire logic under_hit,
  input wire logic cell_over_alert,
  input wire logic cell_under_alert,
  input wire logic path_mismatch_alert,
  // Effective configuration
  input wire logic [14:0] measure_enables,
  input wire logic [11:0] balance_switch_enables,
  input wire logic alternate_path,
  input wire logic bipolar,
  input wire logic [15:0] full_scale_result,
  input wire logic full_scale_force,
  // Test sources
  input wire logic [12:0] cell_source_sink,
  input wire logic mux_even_on,
  input wire logic mux_odd_on
);
  logic [2:0] mode_q, mode_d;
  logic [9:0] src_q, src_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  function automatic logic act(input logic [2:0] m);
    return m == 3'h1 || m == 3'h2 || m == 3'h5 || m == 3'h6;
  endfunction
  // Lagged shadows line up with the registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
      mode_d <= 3'h0;
      src_q <= 10'h000;
      src_d <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == bsd_pkg::ADDR_CONFIG) mode_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == bsd_pkg::ADDR_STATUS) src_q <= reg_wdata[9:0];
      mode_d <= mode_q;
      src_d <= src_q;
    end
  end
  chk_short_force: assert property (mode_d == bsd_pkg::MODE_SHORT |->
    balance_switch_enables == 12'h0 && measure_enables[14:12] == 3'h0 && alternate_path)
    else $error("short mode config");
  chk_open_copy: assert property (mode_d == bsd_pkg::MODE_OPEN |->
    measure_enables == {3'h0, balance_switch_enables} && alternate_path && bipolar)
    else $error("open mode config");
  chk_wire_pattern: assert property (mode_d[2] && act(mode_d) |->
    balance_switch_enables == (mode_d[0] ? 12'h555 : 12'haaa) &&
    measure_enables == {3'h0, balance_switch_enables} && alternate_path && bipolar)
    else $error("wire mode config");
  chk_alert_quiet: assert property (act(mode_q) && act(mode_d) |->
    !cell_over_alert && !cell_under_alert && !path_mismatch_alert)
    else $error("alert in mode");
  chk_alert_pass: assert property (!act(mode_q) && !act(mode_d) && over_hit |=>
    cell_over_alert) else $error("over alert lost");
  chk_under_cause: assert property (cell_under_alert |-> $past(under_hit))
    else $error("stray under alert");
  chk_fs_value: assert property (full_scale_result == 16'hfff0)
    else $error("full scale value");
  chk_fs_bipolar: assert property (full_scale_force |-> bipolar)
    else $error("full scale unipolar");
  chk_sink_zero: assert property (!cell_source_sink[0])
    else $error("input zero sinks");
  chk_mux_route: assert property (src_q == src_d |->
    mux_even_on == (src_d[7] && !(src_d[8] && src_d[9])) &&
    mux_odd_on == (src_d[7] && !(src_d[8] && !src_d[9])))
    else $error("mux routing");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("stray read data");
  cov_short: cover property (mode_d == bsd_pkg::MODE_SHORT);
  cov_wire: cover property (mode_d == bsd_pkg::MODE_ODD_WIRE);
  cov_fs: cover property (full_scale_force);
endmodule
`default_nettype wire

/* sim/bsd_top_test.sv */
// Purpose: Self-checking bench for the switch diagnostic controller
// Assumes: Register reads answer one cycle after the strobe
// Notes: Wire modes settle 1000 cycles before acquiring
`timescale 1ns/1ps
`default_nettype none
module bsd_top_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic hit = 1'b0;
  logic start = 1'b0;
  logic send_all = 1'b0;
  logic [191:0] chan_data = '0;
  logic [191:0] d;
  logic [11:0] pat;
  logic [15:0] reg_rdata, full_scale_result;
  logic res_valid, res_done, alternate_path, bipolar, full_scale_force;
  logic [3:0] res_chan, source_magnitude_code;
  logic [15:0] res_data;
  logic [14:0] measure_enables;
  logic [11:0] balance_switch_enables;
  logic cell_over_alert, cell_under_alert, path_mismatch_alert, mux_even_on, mux_odd_on;
  logic [12:0] cell_source_on, cell_source_sink;
  logic [1:0] aux_source_on, aux_source_sink;
  logic [15:0] src_ctl [4] = '{16'h00fa, 16'h01fa, 16'h03fa, 16'h00ea};
  logic [1:0] mux_exp [4] = '{2'b11, 2'b10, 2'b01, 2'b11};
  int miscompares = 0;
  int n_tests = 0;
  always #50 mclk = ~mclk;
  bsd_top u_bsd_top (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .res_valid, .res_chan, .res_data, .res_done, .over_hit(hit), .under_hit(hit),
    .mismatch_hit(hit), .measure_enables, .balance_switch_enables, .alternate_path,
    .bipolar, .full_scale_result, .full_scale_force, .cell_over_alert, .cell_under_alert,
    .path_mismatch_alert, .cell_source_on, .cell_source_sink, .aux_source_on,
    .aux_source_sink, .source_magnitude_code, .mux_even_on, .mux_odd_on);
  bsd_acq_model u_bsd_acq_model (.mclk, .rst_n, .start, .send_all,
    .chan_en(measure_enables[11:0]), .chan_data, .res_valid, .res_chan, .res_data,
    .res_done);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic acq(input logic all, input logic [191:0] v, input logic [11:0] exp);
    int i;
    @(posedge mclk);
    start <= 1'b1;
    send_all <= all;
    chan_data <= v;
    @(posedge mclk);
    start <= 1'b0;
    for (i = 0; i < 40 && res_done !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 40) begin
      miscompares++;
      end_sim();
    end
    repeat (3) @(posedge mclk);
    rd(bsd_pkg::ADDR_FLAGS, {4'h0, exp});
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(bsd_pkg::ADDR_HIGH_THR, 16'hffff);
    rd(bsd_pkg::ADDR_LOW_THR, 16'h0);
    rd(4'hf, 16'h0);
    check(full_scale_result, 16'hfff0);
    $display("reset test done");
    wr(bsd_pkg::ADDR_MEASURE, 16'h7fff);
    wr(bsd_pkg::ADDR_BALANCE, 16'hff);
    wr(bsd_pkg::ADDR_SHORT_THR, 16'h1000);
    @(posedge mclk);
    hit <= 1'b1;
    wr(bsd_pkg::ADDR_CONFIG, 16'h1);
    settle();
    check({4'h0, balance_switch_enables}, 16'h0);
    check({alternate_path, measure_enables}, 16'h8fff);
    rd(bsd_pkg::ADDR_EFFECTIVE, 16'h8fff);
    check(16'({cell_over_alert, cell_under_alert, path_mismatch_alert}), 16'h0);
    d = {12{16'h2000}};
    d[48 +: 16] = 16'h0800;
    d[64 +: 16] = 16'h1000;
    acq(1'b0, d, 12'h008);
    wr(bsd_pkg::ADDR_CONFIG, 16'h0);
    settle();
    check({alternate_path, measure_enables}, 16'h7fff);
    check({4'h0, balance_switch_enables}, 16'hff);
    check(16'({cell_over_alert, cell_under_alert, path_mismatch_alert}), 16'h7);
    hit <= 1'b0;
    $display("short mode test done");
    wr(bsd_pkg::ADDR_FLAGS, 16'hfff);
    rd(bsd_pkg::ADDR_FLAGS, 16'h0);
    wr(bsd_pkg::ADDR_BALANCE, 16'hf);
    wr(bsd_pkg::ADDR_LOW_THR, 16'h100);
    wr(bsd_pkg::ADDR_HIGH_THR, 16'h200);
    wr(bsd_pkg::ADDR_CONFIG, 16'h2);
    settle();
    check({alternate_path, bipolar, measure_enables[13:0]}, 16'hc00f);
    d = '0;
    d[63:0] = 64'h0300_0200_0100_0050;
    acq(1'b1, d, 12'h009);
    $display("open mode test done");
    for (int k = 0; k < 2; k++) begin
      wr(bsd_pkg::ADDR_FLAGS, 16'hfff);
      wr(bsd_pkg::ADDR_CONFIG, (k == 0) ? 16'h5 : 16'h6);
      repeat (1000) @(posedge mclk);
      #1;
      pat = (k == 0) ? 12'h555 : 12'haaa;
      check({4'h0, balance_switch_enables}, {4'h0, pat});
      check({alternate_path, bipolar, measure_enables[13:0]}, {4'hc, pat});
      acq(1'b0, {12{16'h0300}}, pat);
    end
    $display("sense wire test done");
    wr(bsd_pkg::ADDR_CONFIG, 16'h0);
    wr(bsd_pkg::ADDR_FLAGS, 16'hfff);
    acq(1'b1, '0, 12'h000);
    wr(bsd_pkg::ADDR_CONFIG, 16'h28);
    settle();
    check(16'({full_scale_force, bipolar}), 16'h3);
    $display("full scale test done");
    wr(bsd_pkg::ADDR_SOURCES, 16'h1fff);
    for (int s = 0; s < 4; s++) begin
      wr(bsd_pkg::ADDR_STATUS, src_ctl[s]);
      settle();
      check(16'(cell_source_on), 16'h1fff);
      check(16'(cell_source_sink), src_ctl[s][4] ? 16'h1ffe : 16'h0);
      check(16'({aux_source_sink, aux_source_on, source_magnitude_code}),
        16'({src_ctl[s][4] ? 2'h3 : 2'h0, 2'h3, 4'ha}));
      check(16'({mux_even_on, mux_odd_on}), 16'(mux_exp[s]));
    end
    $display("source test done");
    end_sim();
  end
endmodule
bind bsd_top bsd_monitor u_bsd_monitor (.*);
`default_nettype wire
